/* File: verilog/can_transceiver_fault_flags.v */
// Fault and status flag logic of a CAN FD transceiver: flags, driver enable and fault indicator.
// Assumes pins are synchronous to aclk; mode and analog monitor results are written over AXI4-Lite.
// Operation
// (RQ1) Cold start shows as fault indicator low after entering silent from standby or sleep.
// (RQ2) Cold start flag clears when the mode changes to normal.
// (RQ3) Wake request sets only in standby, go-to-sleep or sleep on wake or power-up.
// (RQ4) Setting the wake request restarts the undervoltage filter timers.
// (RQ5) Wake request clears on entering normal or on core or I/O undervoltage.
// (RQ6) Supply undervoltage flags stay internal, never on the fault indicator.
// (RQ7) Battery undervoltage is a cold start; recovery sets cold start and wake request.
// (RQ8) Core or I/O undervoltage flag sets after the filter time below threshold.
// (RQ9) Six bus short cases are detected while transmitting dominant.
// (RQ10) Bus short flag sets after four faulty dominant-to-recessive transmit transitions.
// (RQ11) Driver stays enabled while the bus short flag is set.
// (RQ12) Bus short clears after four fault-free dominant-to-recessive transitions in normal mode.
// (RQ13) Transmit stuck past the dominant timeout sets a flag shown on normal-to-silent.
// (RQ14) Transmit stuck clears on next transmit rising edge or entry into other modes.
// (RQ15) Transmit falling edge starts a 1.2 ms timer; expiry disables the driver.
// (RQ16) Driver re-enables on next transmit rising edge; receive keeps mirroring the bus.
// (RQ17) Transmit/receive short for the timeout sets a flag, disables driver, shown on normal-to-silent.
// (RQ18) That short clears on rising edge with transmit high, receive low, or mode entry.
// (RQ19) Bus stuck dominant past the bus dominant time sets a flag; clears on receive rise.
// (RQ20) Local faults detected in normal and silent, shown only on normal-to-silent; transmit stuck detected in normal only, the others in every mode.
// (RQ21) Overtemperature disables driver, keeps receive, shows on indicator until temperature falls.
// (RQ22) Go-to-sleep is blocked while the wake request flag is set.
// (RQ23) After wake-up, entering standby drives fault indicator and receive output low.
// (RQ24) Controller reads the indicator right after a normal-to-silent change.
`timescale 1ns/1ps
`default_nettype none
`include "fault_flags_regs.vh"
module can_transceiver_fault_flags #(
  parameter [31:0] dominant_timeout_cyc = `DOMINANT_TIMEOUT_CYC,
  parameter [31:0] bus_dominant_cyc = `BUS_DOMINANT_TIME_CYC,
  parameter [31:0] uv_filter_cyc = `UV_FILTER_TIME_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Controller-side pins
  input wire txd,
  output reg rxd,
  output reg fault_indicator_out,
  // Bus side: received bus level (1 recessive) and driver enable
  input wire bus_rx,
  output reg driver_enable
);
  wire [31:0] mode_reg;
  wire [31:0] inputs_reg;
  wire [31:0] status_word;
  wire [2:0] req_mode;
  reg [2:0] mode;
  reg [2:0] prev_mode;
  reg txd_q;
  reg bus_q;
  reg cold_start_flag;
  reg wake_request_flag;
  reg battery_undervoltage_flag;
  reg bat_uv_q;
  reg bus_short_flag;
  reg [2:0] short_count;
  reg [2:0] clean_count;
  reg short_seen;
  reg transmit_stuck_flag;
  reg tx_rx_short_flag;
  reg bus_stuck_dominant_flag;
  reg overtemperature_shutdown;
  reg show_local;
  reg show_cold;
  reg show_wake;
  wire core_supply_undervoltage_flag;
  wire io_supply_undervoltage_flag;
  wire dto_expired;
  wire txrx_expired;
  wire busdom_expired;
  wire tx_rise;
  wire tx_fall;
  wire rx_rise;
  wire mode_change;
  wire enter_normal;
  wire enter_quiet;
  wire normal_to_silent;
  wire wake_event;
  wire local_clear;

  // Any of normal, standby, go-to-sleep or sleep
  function is_clearing_mode;
    input [2:0] m;
    begin
      is_clearing_mode = (m != `MODE_SILENT);
    end
  endfunction

  // Standby, go-to-sleep or sleep: where wake requests are taken
  function is_low_power;
    input [2:0] m;
    begin
      is_low_power = (m == `MODE_STANDBY) || (m == `MODE_GOTOSLEEP) || (m == `MODE_SLEEP);
    end
  endfunction

  axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .mode_reg(mode_reg),
    .inputs_reg(inputs_reg),
    .status_word(status_word)
  );

  // Undervoltage filters restart on a new wake request (see RQ4, see RQ8)
  hold_timer #(.limit(uv_filter_cyc)) u_core_uv (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(inputs_reg[`IN_CORE_UV]),
    .restart(wake_event && !wake_request_flag),
    .expired(core_supply_undervoltage_flag)
  );

  hold_timer #(.limit(uv_filter_cyc)) u_io_uv (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(inputs_reg[`IN_IO_UV]),
    .restart(wake_event && !wake_request_flag),
    .expired(io_supply_undervoltage_flag)
  );

  // Dominant timeout, armed by a transmit falling edge while driving (see RQ15)
  hold_timer #(.limit(dominant_timeout_cyc)) u_dto (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(!txd && driver_enable),
    .restart(tx_fall),
    .expired(dto_expired)
  );

  // Transmit and receive stuck low together reads as the lines shorted (see RQ17)
  hold_timer #(.limit(dominant_timeout_cyc)) u_txrx (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(!txd && !rxd && bus_rx),
    .restart(1'b0),
    .expired(txrx_expired)
  );

  // Bus held dominant (see RQ19)
  hold_timer #(.limit(bus_dominant_cyc)) u_busdom (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(!bus_rx),
    .restart(1'b0),
    .expired(busdom_expired)
  );

  // Go-to-sleep request is held off while a wake request stands (see RQ22)
  assign req_mode = mode_reg[2:0];
  assign tx_rise = txd && !txd_q;
  assign tx_fall = !txd && txd_q;
  assign rx_rise = bus_rx && !bus_q;
  assign mode_change = (mode != prev_mode);
  assign enter_normal = mode_change && (mode == `MODE_NORMAL);
  assign enter_quiet = mode_change && is_clearing_mode(mode);
  assign normal_to_silent = mode_change && (prev_mode == `MODE_NORMAL) && (mode == `MODE_SILENT);
  assign wake_event = is_low_power(mode) && (inputs_reg[`IN_LOCAL_WAKE] || inputs_reg[`IN_REMOTE_WAKE]);
  assign local_clear = enter_quiet;

  // Mode tracking and edge history
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode <= `MODE_STANDBY;
      prev_mode <= `MODE_STANDBY;
      txd_q <= 1'b1;
      bus_q <= 1'b1;
      bat_uv_q <= 1'b0;
    end else begin
      prev_mode <= mode;
      txd_q <= txd;
      bus_q <= bus_rx;
      bat_uv_q <= inputs_reg[`IN_BAT_UV];
      if (req_mode == `MODE_GOTOSLEEP && wake_request_flag)
        mode <= mode; // see RQ22
      else if (req_mode <= `MODE_SLEEP)
        mode <= req_mode;
    end
  end

  // Supply flags: battery undervoltage is a cold start on recovery
  always @(posedge aclk) begin
    if (!aresetn) begin
      battery_undervoltage_flag <= 1'b0;
      cold_start_flag <= 1'b1;
      wake_request_flag <= 1'b1;
    end else begin
      battery_undervoltage_flag <= inputs_reg[`IN_BAT_UV];
      if (bat_uv_q && !inputs_reg[`IN_BAT_UV])
        cold_start_flag <= 1'b1; // see RQ7
      else if (enter_normal)
        cold_start_flag <= 1'b0; // see RQ2
      // Set wins over clear when both arrive together
      if ((bat_uv_q && !inputs_reg[`IN_BAT_UV]) || wake_event)
        wake_request_flag <= 1'b1; // see RQ3, see RQ7
      else if (enter_normal || core_supply_undervoltage_flag || io_supply_undervoltage_flag)
        wake_request_flag <= 1'b0; // see RQ5
    end
  end

  // Bus short counting over transmit dominant-to-recessive edges (see RQ9)
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_short_flag <= 1'b0;
      short_count <= 3'h0;
      clean_count <= 3'h0;
      short_seen <= 1'b0;
    end else if (mode != `MODE_NORMAL) begin
      bus_short_flag <= 1'b0;
      short_count <= 3'h0;
      clean_count <= 3'h0;
      short_seen <= 1'b0;
    end else begin
      // Latch the fault while transmitting dominant, judge it at the rising edge
      if (!txd && inputs_reg[`IN_BUS_SHORT])
        short_seen <= 1'b1;
      if (tx_rise) begin
        short_seen <= 1'b0;
        if (short_seen) begin
          clean_count <= 3'h0;
          if (short_count == `BUS_SHORT_EDGES - 3'h1)
            bus_short_flag <= 1'b1; // see RQ10
          if (short_count != `BUS_SHORT_EDGES)
            short_count <= short_count + 3'h1;
        end else begin
          short_count <= 3'h0;
          if (clean_count == `BUS_SHORT_EDGES - 3'h1)
            bus_short_flag <= 1'b0; // see RQ12
          if (clean_count != `BUS_SHORT_EDGES)
            clean_count <= clean_count + 3'h1;
        end
      end
    end
  end

  // Local faults: transmit stuck detected in normal only, the other two in every mode (see RQ20)
  always @(posedge aclk) begin
    if (!aresetn) begin
      transmit_stuck_flag <= 1'b0;
      tx_rx_short_flag <= 1'b0;
      bus_stuck_dominant_flag <= 1'b0;
    end else begin
      if (dto_expired)
        transmit_stuck_flag <= 1'b1; // see RQ13
      else if (tx_rise || local_clear)
        transmit_stuck_flag <= 1'b0; // see RQ14
      if (txrx_expired)
        tx_rx_short_flag <= 1'b1; // see RQ17
      else if ((tx_rise && !rxd) || local_clear)
        tx_rx_short_flag <= 1'b0; // see RQ18
      if (busdom_expired)
        bus_stuck_dominant_flag <= 1'b1; // see RQ19
      else if (rx_rise || local_clear)
        bus_stuck_dominant_flag <= 1'b0; // see RQ19
    end
  end

  // Overtemperature follows the monitor, which carries its own hysteresis (see RQ21)
  always @(posedge aclk) begin
    if (!aresetn)
      overtemperature_shutdown <= 1'b0;
    else
      overtemperature_shutdown <= inputs_reg[`IN_OVERTEMP];
  end

  // Indication latches, taken on the transition that reveals them
  always @(posedge aclk) begin
    if (!aresetn) begin
      show_local <= 1'b0;
      show_cold <= 1'b0;
      show_wake <= 1'b0;
    end else begin
      if (normal_to_silent)
        show_local <= transmit_stuck_flag || tx_rx_short_flag || bus_stuck_dominant_flag; // see RQ20
      else if (mode_change)
        show_local <= 1'b0;
      if (mode_change && mode == `MODE_SILENT &&
          (prev_mode == `MODE_STANDBY || prev_mode == `MODE_SLEEP))
        show_cold <= cold_start_flag; // see RQ1
      else if (mode_change)
        show_cold <= 1'b0;
      if (mode_change && mode == `MODE_STANDBY)
        show_wake <= wake_request_flag; // see RQ23
      else if (mode_change || !wake_request_flag)
        show_wake <= 1'b0;
    end
  end

  // Outputs; undervoltage flags deliberately feed none of them (see RQ6)
  always @(posedge aclk) begin
    if (!aresetn) begin
      driver_enable <= 1'b0;
      rxd <= 1'b1;
      fault_indicator_out <= 1'b1;
    end else begin
      // Bus short does not gate the driver (see RQ11); timeouts do (see RQ15, see RQ16)
      driver_enable <= (mode == `MODE_NORMAL) && !transmit_stuck_flag && !dto_expired &&
                       !tx_rx_short_flag && !overtemperature_shutdown;
      // Receive mirrors the bus except when signalling a wake (see RQ16, see RQ23)
      rxd <= show_wake ? 1'b0 : bus_rx;
      fault_indicator_out <= !(show_local || show_cold || show_wake || overtemperature_shutdown ||
                               (bus_short_flag && mode == `MODE_NORMAL)); // see RQ10, see RQ21
    end
  end

  // Status word for software
  assign status_word = {19'h00000, (wake_request_flag && req_mode == `MODE_GOTOSLEEP),
                        fault_indicator_out, driver_enable, overtemperature_shutdown,
                        bus_stuck_dominant_flag, tx_rx_short_flag, transmit_stuck_flag,
                        bus_short_flag, io_supply_undervoltage_flag, core_supply_undervoltage_flag,
                        battery_undervoltage_flag, wake_request_flag, cold_start_flag};
endmodule
`default_nettype wire

/* File: verilog/fault_flags_regs.vh */
// Constants for the transceiver fault flag block: register offsets, field positions, mode codes and timing.
// Assumes a 40 MHz aclk and an AXI4-Lite slave with 32-bit data.
`ifndef FAULT_FLAGS_REGS_VH
`define FAULT_FLAGS_REGS_VH

// Clock period in ns
`define CLK_PERIOD_NS 25
// Dominant timeout in us (1.2 ms) and its cycle count, rounded down
`define DOMINANT_TIMEOUT_US 1200
`define DOMINANT_TIMEOUT_CYC ((`DOMINANT_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
// Bus dominant time in us and undervoltage filter time in us (plain defaults)
`define BUS_DOMINANT_TIME_US 1200
`define BUS_DOMINANT_TIME_CYC ((`BUS_DOMINANT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define UV_FILTER_TIME_US 200
`define UV_FILTER_TIME_CYC ((`UV_FILTER_TIME_US * 1000) / `CLK_PERIOD_NS)
// Edge count for bus short set and clear
`define BUS_SHORT_EDGES 3'h4

// Register byte offsets
`define REG_MODE 12'h000
`define REG_INPUTS 12'h004
`define REG_STATUS 12'h008
`define REG_MODE_RESET 32'h0000_0000

// Mode codes in REG_MODE[2:0]
`define MODE_NORMAL 3'h0
`define MODE_SILENT 3'h1
`define MODE_STANDBY 3'h2
`define MODE_GOTOSLEEP 3'h3
`define MODE_SLEEP 3'h4

// REG_INPUTS field positions (condition inputs from analog monitors)
`define IN_BAT_UV 0
`define IN_CORE_UV 1
`define IN_IO_UV 2
`define IN_LOCAL_WAKE 3
`define IN_REMOTE_WAKE 4
`define IN_BUS_SHORT 5
`define IN_OVERTEMP 6

// REG_STATUS field positions
`define ST_COLD_START 0
`define ST_WAKE_REQUEST 1
`define ST_BAT_UV 2
`define ST_CORE_UV 3
`define ST_IO_UV 4
`define ST_BUS_SHORT 5
`define ST_TX_STUCK 6
`define ST_TXRX_SHORT 7
`define ST_BUS_DOM 8
`define ST_OVERTEMP 9
`define ST_DRIVER_EN 10
`define ST_FAULT_OUT 11
`define ST_SLEEP_BLOCK 12

`endif

/* File: verilog/hold_timer.v */
// Counter that reports when a level has stood true for more than a set number of cycles.
// Assumes the level is synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
  parameter [31:0] limit = 32'h0000_0010
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Level to watch and restart
  input wire level,
  input wire restart,
  // High once the level has stood longer than the limit
  output reg expired
);
  reg [31:0] count;

  // Count while the level holds; saturate so expiry stays asserted
  always @(posedge aclk) begin
    if (!aresetn || !level || restart) begin
      count <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (count < limit) begin
      count <= count + 32'h0000_0001;
      expired <= 1'b0;
    end else begin
      expired <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/axil_regs.v */
// AXI4-Lite slave holding the mode and monitor-input registers and showing the status word.
// Assumes one outstanding write and one outstanding read from the master.
`timescale 1ns/1ps
`default_nettype none
`include "fault_flags_regs.vh"
module axil_regs (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write address and data
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // Write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address and data
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Register contents
  output reg [31:0] mode_reg,
  output reg [31:0] inputs_reg,
  input wire [31:0] status_word
);
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  integer i;

  // Take address and data in either order, one write at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write side: store, apply byte strobes, answer SLVERR on unmapped address
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      mode_reg <= `REG_MODE_RESET;
      inputs_reg <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
          if (w_strb[i] && aw_addr[11:2] == `REG_MODE >> 2)
            mode_reg[i*8 +: 8] <= w_data[i*8 +: 8];
          if (w_strb[i] && aw_addr[11:2] == `REG_INPUTS >> 2)
            inputs_reg[i*8 +: 8] <= w_data[i*8 +: 8];
        end
        if (aw_addr[11:2] != `REG_MODE >> 2 && aw_addr[11:2] != `REG_INPUTS >> 2 &&
            aw_addr[11:2] != `REG_STATUS >> 2)
          s_axi_bresp <= 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read side: answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr[11:2])
        `REG_MODE >> 2: s_axi_rdata <= mode_reg;
        `REG_INPUTS >> 2: s_axi_rdata <= inputs_reg;
        `REG_STATUS >> 2: s_axi_rdata <= status_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/can_transceiver_fault_flags_assertions.sv */
// Checker: bus handshakes, receive mirror, dominant timeout.
// Bound to the block top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module fault_flags_checker #(
  parameter [31:0] dominant_timeout_cyc = 32'h0000_0010
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pins
  input wire txd,
  input wire rxd,
  input wire fault_indicator_out,
  input wire bus_rx,
  input wire driver_enable
);
  reg [31:0] low_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles txd has stood dominant, saturating
  always @(posedge aclk) begin
    if (!aresetn || txd)
      low_cnt <= 32'h0;
    else if (low_cnt != 32'hffff_ffff)
      low_cnt <= low_cnt + 32'h1;
  end
  AST_DTO_OFF: assert property (low_cnt > dominant_timeout_cyc + 32'h4 |-> !driver_enable)
    else $error("driver on");
  AST_RXD_MIRROR: assert property ($past(aresetn) && $past(fault_indicator_out) && fault_indicator_out
    |-> rxd == $past(bus_rx)) else $error("rxd mirror");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("b dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("r dropped");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("b late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("r late");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken");
  AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("aw or w taken");
  // Main scenarios reached
  cover property (!driver_enable && !txd);
  cover property (!fault_indicator_out && driver_enable);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind can_transceiver_fault_flags fault_flags_checker #(.dominant_timeout_cyc(dominant_timeout_cyc)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd),
  .rxd(rxd), .fault_indicator_out(fault_indicator_out), .bus_rx(bus_rx), .driver_enable(driver_enable));
`default_nettype wire

/* File: test/can_ctrl_model.sv */
// Controller model: a dominant bit of set length, then a recessive gap.
// Send is a one-cycle request, taken when idle.
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request
  input wire logic send,
  input wire logic [15:0] dom_len,
  // Pins
  output logic txd,
  output logic busy
);
  logic [15:0] cnt;
  // Idles recessive, as the pin pull-up would leave it; gap keeps edges apart
  always @(posedge aclk) begin
    if (!aresetn) begin
      txd <= 1'b1;
      busy <= 1'b0;
      cnt <= 16'h0;
    end else if (send && !busy) begin
      txd <= 1'b0;
      busy <= 1'b1;
      cnt <= dom_len;
    end else if (cnt != 16'h0) begin
      cnt <= cnt - 16'h1;
    end else if (!txd) begin
      txd <= 1'b1;
      cnt <= 16'h4;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/test_can_transceiver_fault_flags.sv */
// Bench for the fault flag block over the register bus.
// The bus follows txd while driven and may be forced dominant.
`timescale 1ns/1ps
`default_nettype none
`include "fault_flags_regs.vh"
module test_can_transceiver_fault_flags;
  localparam [31:0] T = 32'h0000_0010;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic txd, rxd, fault, bus_rx, drv, send, busy, bus_force;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, sv;
  logic [1:0] bresp, rresp, r;
  logic [15:0] dom_len;
  int err_count, num_checks;
  // Bus dominant only when driven so or forced stuck
  assign bus_rx = bus_force ? 1'b0 : (drv ? txd : 1'b1);
  can_transceiver_fault_flags #(.dominant_timeout_cyc(T), .bus_dominant_cyc(T), .uv_filter_cyc(T)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .txd(txd), .rxd(rxd), .fault_indicator_out(fault), .bus_rx(bus_rx), .driver_enable(drv));
  can_ctrl_model ctrl (.aclk(aclk), .aresetn(aresetn), .send(send), .dom_len(dom_len), .txd(txd), .busy(busy));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Driver, indicator, receive pins
  task pins(input logic [2:0] e);
    check({29'h0, drv, fault, rxd}, {29'h0, e});
  endtask
  task lim(input int n, input int b);
    if (n >= b) begin
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      stop_test;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write; each channel released when taken
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 60);
    bready <= 1'b0;
    lim(n, 60);
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task inp(input logic [31:0] d);
    wr(`REG_INPUTS, d, 2'b00);
  endtask
  // Mode write, then time for the pins to follow
  task md(input logic [2:0] m);
    wr(`REG_MODE, {29'h0, m}, 2'b00);
    cyc(4);
  endtask
  task rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 60);
    rready <= 1'b0;
    sv = rdata;
    r = rresp;
    lim(n, 60);
  endtask
  task st(input logic [31:0] m, input logic [31:0] e);
    rd(`REG_STATUS);
    check(sv & m, e);
  endtask
  task frame(input logic [15:0] len);
    int n;
    n = 0;
    @(posedge aclk);
    {send, dom_len} <= {1'b1, len};
    @(posedge aclk);
    send <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (busy && n < 200);
    lim(n, 200);
  endtask
  task t_start;
    cyc(4);
    rd(`REG_MODE);
    check(sv, `REG_MODE_RESET);
    st(32'h3, 32'h0);
    pins(3'b111);
    $display("start done");
  endtask
  task t_dto;
    frame(T[15:0] + 16'h8);
    pins(3'b111);
    fork
      frame(16'h003c);
      begin
        cyc(T + 8);
        pins(3'b011);
        md(`MODE_SILENT);
        pins(3'b001);
      end
    join
    st(32'h40, 32'h0);
    md(`MODE_NORMAL);
    pins(3'b111);
    $display("timeout done");
  endtask
  task t_short;
    inp(32'h1 << `IN_BUS_SHORT);
    repeat (3) frame(16'h3);
    pins(3'b111);
    frame(16'h3);
    pins(3'b101);
    inp(32'h0);
    repeat (3) frame(16'h3);
    pins(3'b101);
    frame(16'h3);
    pins(3'b111);
    $display("short done");
  endtask
  task t_uv;
    inp(32'h1 << `IN_CORE_UV);
    st(32'h8, 32'h0);
    cyc(T + 4);
    st(32'h8, 32'h8);
    pins(3'b111);
    inp(32'h0);
    $display("undervoltage done");
  endtask
  task t_wake;
    inp(32'h1 << `IN_LOCAL_WAKE);
    inp(32'h0);
    st(32'h2, 32'h0);
    md(`MODE_STANDBY);
    inp(32'h1 << `IN_BAT_UV);
    inp(32'h0);
    st(32'h3, 32'h3);
    md(`MODE_GOTOSLEEP);
    st(32'h1000, 32'h1000);
    md(`MODE_SILENT);
    pins(3'b001);
    md(`MODE_STANDBY);
    pins(3'b000);
    md(`MODE_NORMAL);
    st(32'h3, 32'h0);
    pins(3'b111);
    $display("wake done");
  endtask
  task t_temp;
    inp(32'h1 << `IN_OVERTEMP);
    cyc(3);
    pins(3'b001);
    bus_force <= 1'b1;
    cyc(3);
    pins(3'b000);
    bus_force <= 1'b0;
    inp(32'h0);
    cyc(4);
    pins(3'b111);
    $display("temperature done");
  endtask
  task t_regs;
    rd(12'h00c);
    check(sv, 32'h0);
    check({30'h0, r}, 32'h2);
    wr(12'h00c, 32'h0, 2'b10);
    wr(`REG_STATUS, 32'hffff_ffff, 2'b00);
    st(32'hfff, 32'hc00);
    $display("registers done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, send, bus_force} = 8'h0;
    {awaddr, araddr, wdata, dom_len} = 72'h0;
    err_count = 0;
    num_checks = 0;
    repeat (6) @(posedge aclk);
    pins(3'b011);
    aresetn <= 1'b1;
    t_start;
    t_dto;
    t_short;
    t_uv;
    t_wake;
    t_temp;
    t_regs;
    stop_test;
  end
endmodule
`default_nettype wire
